// ---- rtl/espg_pkg.sv ----
// package: types and constants of the engine spark pulse generator
package espg_pkg;

  // ----------------------------------------------------------------
  // widths and rates
  // ----------------------------------------------------------------
  localparam int ANG_W        = 16;
  localparam int DW_W         = 24;
  localparam int ADDR_W       = 8;
  localparam int CLK_HZ       = 200_000_000;
  localparam int TICK_HZ      = 40_000_000;
  localparam int TICK_DIV     = CLK_HZ / TICK_HZ;
  localparam logic [2:0] TICK_LAST = 3'(TICK_DIV - 1);

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] START_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] END_OFS    = 8'h08;
  localparam logic [ADDR_W-1:0] CUTOFF_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] DWELL_OFS  = 8'h10;
  localparam logic [ADDR_W-1:0] MIN_OFS    = 8'h14;
  localparam logic [ADDR_W-1:0] MAX_OFS    = 8'h18;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h1c;
  localparam logic [ADDR_W-1:0] LAST_OFS   = 8'h20;
  localparam logic [ADDR_W-1:0] PERIOD_OFS = 8'h24;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_POL_BIT  = 2;
  localparam logic [ANG_W-1:0] ANG_RST = 16'h0000;
  localparam logic [DW_W-1:0]  DW_RST  = 24'h000000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_CHARGE = 2'b01,
    ST_HOLD   = 2'b11,
    ST_DONE   = 2'b10
  } espg_state_t;

  typedef struct packed {
    logic [ANG_W-1:0] crank_angle_tick;
    logic [ANG_W-1:0] max_angle_tick;
  } espg_pos_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } espg_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } espg_apb_rsp_t;

  typedef struct packed {
    logic             ignition_enable;
    logic             timing_mode_select;
    logic             output_polarity_invert;
    logic [ANG_W-1:0] leading_edge_angle;
    logic [ANG_W-1:0] trailing_edge_angle;
    logic [ANG_W-1:0] cycle_reset_angle;
    logic [DW_W-1:0]  requested_charge_time;
    logic [DW_W-1:0]  minimum_charge_time;
    logic [DW_W-1:0]  maximum_charge_time;
  } espg_cfg_t;

endpackage

// ---- rtl/espg_spark.sv ----
// module: engine spark pulse generator with apb configuration
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps

module espg_spark #(
  parameter logic [7:0] UNLOCK_KEY = 8'h5a  // arbitrary value
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire espg_pkg::espg_apb_req_t i_apb,
  input  wire espg_pkg::espg_pos_t    i_engine_position_bundle,
  input  wire logic [7:0]             i_key,
  output espg_pkg::espg_apb_rsp_t     o_apb,
  output logic                        o_ignition_pulse_output
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    espg_pkg::espg_cfg_t                 cfg;
    espg_pkg::espg_state_t               state;
    logic [espg_pkg::ANG_W-1:0]          pos_prev;
    logic [espg_pkg::DW_W-1:0]           per_cnt;
    logic [espg_pkg::DW_W-1:0]           period;
    logic [espg_pkg::DW_W-1:0]           dwell_cnt;
    logic [espg_pkg::DW_W-1:0]           last_dwell;
    logic [2:0]                          div_cnt;
    logic                                tick;
    logic                                out;
    espg_pkg::espg_apb_rsp_t             rsp;
  } espg_st_t;

  espg_st_t st_ff;
  espg_st_t nxt_st;

  // ----------------------------------------------------------------
  // conditions
  // ----------------------------------------------------------------
  logic [espg_pkg::ANG_W-1:0]              pos;
  logic [espg_pkg::ANG_W-1:0]              rem;
  logic [espg_pkg::ANG_W+espg_pkg::DW_W-1:0] predict;
  logic                                    unlock;
  logic                                    run;
  logic                                    at_start;
  logic                                    at_end;
  logic                                    at_cut;
  logic                                    dwell_due;
  logic                                    min_met;
  logic                                    max_hit;
  logic                                    active;
  logic                                    pos_moved;
  logic                                    acc_first;
  logic                                    acc_done;

  assign pos       = i_engine_position_bundle.crank_angle_tick;
  assign unlock    = (i_key == UNLOCK_KEY);
  assign run       = st_ff.cfg.ignition_enable && unlock;
  assign at_start  = (pos == st_ff.cfg.leading_edge_angle);
  assign at_end    = (pos == st_ff.cfg.trailing_edge_angle);
  assign at_cut    = (pos == st_ff.cfg.cycle_reset_angle);
  assign pos_moved = (pos != st_ff.pos_prev);
  // angle still to go up to the trailing edge, wrapping per cycle
  assign rem = (st_ff.cfg.trailing_edge_angle >= pos) ?
               espg_pkg::ANG_W'(st_ff.cfg.trailing_edge_angle - pos) :
               espg_pkg::ANG_W'(st_ff.cfg.trailing_edge_angle +
                                i_engine_position_bundle.max_angle_tick - pos);
  assign predict = {{espg_pkg::DW_W{1'b0}}, rem} *
                   {{espg_pkg::ANG_W{1'b0}}, st_ff.period};
  assign dwell_due = (st_ff.period != 24'h000000) &&
                     (predict <= {{espg_pkg::ANG_W{1'b0}},
                                  st_ff.cfg.requested_charge_time});
  assign min_met   = (st_ff.dwell_cnt >= st_ff.cfg.minimum_charge_time);
  assign max_hit   = (st_ff.dwell_cnt >= st_ff.cfg.maximum_charge_time);
  assign active    = (st_ff.state == espg_pkg::ST_CHARGE) ||
                     (st_ff.state == espg_pkg::ST_HOLD);
  assign acc_first = i_apb.psel && i_apb.penable && !st_ff.rsp.pready;
  assign acc_done  = i_apb.psel && i_apb.penable && st_ff.rsp.pready;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic hit;
    logic [31:0] rd;
    hit    = 1'b1;
    rd     = 32'h00000000;
    nxt_st = st_ff;

    // 40 MHz tick enable
    nxt_st.tick = (st_ff.div_cnt == espg_pkg::TICK_LAST);
    if (st_ff.div_cnt == espg_pkg::TICK_LAST) begin
      nxt_st.div_cnt = 3'h0;
    end else begin
      nxt_st.div_cnt = st_ff.div_cnt + 3'h1;
    end

    // engine speed: ticks between crank angle steps
    nxt_st.pos_prev = pos;
    if (pos_moved) begin
      nxt_st.period  = st_ff.per_cnt;
      // a tick on the step edge opens the new interval, so phase cannot skew it
      nxt_st.per_cnt = st_ff.tick ? 24'h000001 : 24'h000000;
    end else if (st_ff.tick && (st_ff.per_cnt != 24'hffffff)) begin
      nxt_st.per_cnt = st_ff.per_cnt + 24'h000001;
    end

    // dwell counter in 40 MHz ticks
    if (active && st_ff.tick && (st_ff.dwell_cnt != 24'hffffff)) begin
      nxt_st.dwell_cnt = st_ff.dwell_cnt + 24'h000001;
    end

    // pulse sequencer
    if (!run) begin
      nxt_st.state = espg_pkg::ST_IDLE;
    end else if (at_cut) begin
      nxt_st.state = espg_pkg::ST_IDLE;
    end else begin
      case (st_ff.state)
        espg_pkg::ST_IDLE: begin
          if (st_ff.cfg.timing_mode_select ? at_start : dwell_due) begin
            nxt_st.state     = espg_pkg::ST_CHARGE;
            nxt_st.dwell_cnt = 24'h000000;
          end
        end
        espg_pkg::ST_CHARGE: begin
          if (max_hit) begin
            nxt_st.state = espg_pkg::ST_DONE;
          end else if (at_end) begin
            nxt_st.state = min_met ? espg_pkg::ST_DONE :
                                     espg_pkg::ST_HOLD;
          end
        end
        espg_pkg::ST_HOLD: begin
          if (min_met || max_hit) begin
            nxt_st.state = espg_pkg::ST_DONE;
          end
        end
        espg_pkg::ST_DONE: begin
          nxt_st.state = espg_pkg::ST_DONE;
        end
        default: begin
          nxt_st.state = espg_pkg::ST_IDLE;
        end
      endcase
    end
    if (active && (nxt_st.state != espg_pkg::ST_CHARGE) &&
        (nxt_st.state != espg_pkg::ST_HOLD)) begin
      nxt_st.last_dwell = st_ff.dwell_cnt;
    end

    // apb write, taken at the edge that sees pready high
    if (acc_done && i_apb.pwrite) begin
      case (i_apb.paddr)
        espg_pkg::CTRL_OFS: begin
          nxt_st.cfg.ignition_enable        = i_apb.pwdata[espg_pkg::CTRL_EN_BIT];
          nxt_st.cfg.timing_mode_select     = i_apb.pwdata[espg_pkg::CTRL_MODE_BIT];
          nxt_st.cfg.output_polarity_invert = i_apb.pwdata[espg_pkg::CTRL_POL_BIT];
        end
        espg_pkg::START_OFS:  nxt_st.cfg.leading_edge_angle    = i_apb.pwdata[15:0];
        espg_pkg::END_OFS:    nxt_st.cfg.trailing_edge_angle   = i_apb.pwdata[15:0];
        espg_pkg::CUTOFF_OFS: nxt_st.cfg.cycle_reset_angle     = i_apb.pwdata[15:0];
        espg_pkg::DWELL_OFS:  nxt_st.cfg.requested_charge_time = i_apb.pwdata[23:0];
        espg_pkg::MIN_OFS:    nxt_st.cfg.minimum_charge_time   = i_apb.pwdata[23:0];
        espg_pkg::MAX_OFS:    nxt_st.cfg.maximum_charge_time   = i_apb.pwdata[23:0];
        default: begin
        end
      endcase
    end

    // apb read data and answer, one wait state
    case (i_apb.paddr)
      espg_pkg::CTRL_OFS:   rd = {29'h0, st_ff.cfg.output_polarity_invert,
                                  st_ff.cfg.timing_mode_select,
                                  st_ff.cfg.ignition_enable};
      espg_pkg::START_OFS:  rd = {16'h0, st_ff.cfg.leading_edge_angle};
      espg_pkg::END_OFS:    rd = {16'h0, st_ff.cfg.trailing_edge_angle};
      espg_pkg::CUTOFF_OFS: rd = {16'h0, st_ff.cfg.cycle_reset_angle};
      espg_pkg::DWELL_OFS:  rd = {8'h0, st_ff.cfg.requested_charge_time};
      espg_pkg::MIN_OFS:    rd = {8'h0, st_ff.cfg.minimum_charge_time};
      espg_pkg::MAX_OFS:    rd = {8'h0, st_ff.cfg.maximum_charge_time};
      espg_pkg::STATUS_OFS: rd = {28'h0, unlock, active, st_ff.state};
      espg_pkg::LAST_OFS:   rd = {8'h0, st_ff.last_dwell};
      espg_pkg::PERIOD_OFS: rd = {8'h0, st_ff.period};
      default:              hit = 1'b0;
    endcase
    nxt_st.rsp.pready  = acc_first;
    nxt_st.rsp.pslverr = acc_first && !hit;
    nxt_st.rsp.prdata  = (acc_first && hit && !i_apb.pwrite) ? rd : 32'h00000000;

    // output level with polarity
    nxt_st.out = ((nxt_st.state == espg_pkg::ST_CHARGE) ||
                  (nxt_st.state == espg_pkg::ST_HOLD)) ^
                 nxt_st.cfg.output_polarity_invert;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_apb                   = st_ff.rsp;
  assign o_ignition_pulse_output = st_ff.out;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_tick_gap;
    !st_ff.tick [*4] ##1 st_ff.tick;
  endsequence

  sequence s_access_start;
    acc_first;
  endsequence

  sequence s_answer;
    st_ff.rsp.pready ##1 !st_ff.rsp.pready;
  endsequence

  sequence s_charge_entry;
    st_ff.state == espg_pkg::ST_IDLE ##1 st_ff.state == espg_pkg::ST_CHARGE;
  endsequence

  sequence s_hold_wait;
    run && !at_cut && st_ff.state == espg_pkg::ST_HOLD;
  endsequence

  sequence s_idle_armed;
    run && !at_cut && st_ff.state == espg_pkg::ST_IDLE;
  endsequence

  tick_rate_a: assert property (st_ff.tick |=> s_tick_gap)
    else $error("tick enable not every fifth clock");

  apb_answer_a: assert property (s_access_start |=> s_answer)
    else $error("apb answer not one cycle after access");

  enable_off_a: assert property (!st_ff.cfg.ignition_enable |=> !active)
    else $error("pulse active while disabled");

  key_lock_a: assert property (!unlock |=> !active ##0
                               (o_ignition_pulse_output == st_ff.cfg.output_polarity_invert))
    else $error("pulse active without key");

  out_level_a: assert property (o_ignition_pulse_output ==
                                (active ^ st_ff.cfg.output_polarity_invert))
    else $error("output level disagrees with pulse and polarity");

  leading_angle_a: assert property (run && !at_cut && st_ff.state == espg_pkg::ST_IDLE &&
                                    st_ff.cfg.timing_mode_select && at_start
                                    |=> st_ff.state == espg_pkg::ST_CHARGE)
    else $error("pulse did not start at leading angle");

  dwell_start_a: assert property (run && !at_cut && st_ff.state == espg_pkg::ST_IDLE &&
                                  !st_ff.cfg.timing_mode_select && dwell_due
                                  |=> st_ff.state == espg_pkg::ST_CHARGE &&
                                      st_ff.dwell_cnt == 24'h000000)
    else $error("dwell mode start missed");

  trailing_end_a: assert property (run && !at_cut && st_ff.state == espg_pkg::ST_CHARGE &&
                                   at_end && min_met && !max_hit
                                   |=> st_ff.state == espg_pkg::ST_DONE)
    else $error("pulse did not end at trailing angle");

  min_extend_a: assert property (run && !at_cut && st_ff.state == espg_pkg::ST_CHARGE &&
                                 at_end && !min_met && !max_hit
                                 |=> active)
    else $error("short pulse not extended");

  max_stop_a: assert property (active && max_hit |=> !active)
    else $error("pulse exceeded maximum dwell");

  cutoff_reset_a: assert property (at_cut |=> st_ff.state == espg_pkg::ST_IDLE)
    else $error("cutoff did not reset sequencer");

  run_idle_a: assert property (!run |=> st_ff.state == espg_pkg::ST_IDLE)
    else $error("sequencer left idle while locked or disabled");

  charge_clear_a: assert property (s_charge_entry |-> st_ff.dwell_cnt == 24'h000000)
    else $error("dwell counter not cleared at pulse start");

  dwell_count_a: assert property (active && st_ff.tick && st_ff.dwell_cnt != 24'hffffff
                                  |=> st_ff.dwell_cnt ==
                                      $past(st_ff.dwell_cnt) + 24'h000001)
    else $error("dwell counter missed a tick");

  div_range_a: assert property (st_ff.div_cnt <= espg_pkg::TICK_LAST)
    else $error("tick divider out of range");

  hold_release_a: assert property (s_hold_wait ##0 min_met
                                   |=> st_ff.state == espg_pkg::ST_DONE)
    else $error("held pulse not ended at minimum dwell");

  hold_stay_a: assert property (s_hold_wait ##0 (!min_met && !max_hit)
                                |=> st_ff.state == espg_pkg::ST_HOLD)
    else $error("held pulse ended before minimum dwell");

  done_wait_a: assert property (run && !at_cut && st_ff.state == espg_pkg::ST_DONE
                                |=> st_ff.state == espg_pkg::ST_DONE)
    else $error("second pulse in one engine cycle");

  dwell_ignored_a: assert property (s_idle_armed ##0
                                    (st_ff.cfg.timing_mode_select && !at_start)
                                    |=> st_ff.state == espg_pkg::ST_IDLE)
    else $error("start/end mode started away from leading angle");

  start_ignored_a: assert property (s_idle_armed ##0
                                    (!st_ff.cfg.timing_mode_select && !dwell_due)
                                    |=> st_ff.state == espg_pkg::ST_IDLE)
    else $error("dwell mode started before dwell was due");

  period_track_a: assert property (pos_moved |=> st_ff.period == $past(st_ff.per_cnt))
    else $error("engine speed not captured at crank step");

  write_rdata_a: assert property (acc_first && i_apb.pwrite |=> st_ff.rsp.prdata == 32'h0)
    else $error("read data not zero on write");

  error_ready_a: assert property (st_ff.rsp.pslverr |-> st_ff.rsp.pready)
    else $error("error answer without ready");

endmodule

// ---- sim/espg_coil_model.sv ----
// partner: external ignition driver that times each charge it receives
`timescale 1ns/1ps

module espg_coil_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_line,
  input  wire logic        i_invert,
  input  wire logic [15:0] i_pos,
  output logic      [31:0] o_count,
  output logic      [31:0] o_len,
  output logic      [31:0] o_start_pos,
  output logic      [31:0] o_end_pos
);
  // ----------------------------------------------------------------
  // charge detection
  // ----------------------------------------------------------------
  logic        active;
  logic        act_ff;
  logic [31:0] run;

  assign active = i_line ^ i_invert;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      act_ff      <= 1'b0;
      run         <= '0;
      o_count     <= '0;
      o_len       <= '0;
      o_start_pos <= '0;
      o_end_pos   <= '0;
    end else begin
      act_ff <= active;
      if (active && !act_ff) begin
        o_start_pos <= 32'(i_pos);
        run         <= 32'h1;
      end else if (active) begin
        run <= run + 32'h1;
      end
      if (!active && act_ff) begin
        o_count   <= o_count + 32'h1;
        o_len     <= run;
        o_end_pos <= 32'(i_pos);
      end
    end
  end
endmodule

// ---- sim/engine_spark_pulse_generator_tb.sv ----
// testbench: spark pulse generator over apb with crank stimulus
`timescale 1ns/1ps

module engine_spark_pulse_generator_tb;
  localparam logic [7:0] KEY  = 8'h5a;  // arbitrary value
  localparam int         MAXA = 64;
  logic                    i_clk;
  logic                    i_rst;
  logic                    pol;
  logic                    line;
  logic                    aux_line;
  logic                    ttl_channel_input;
  logic                    er;
  logic [7:0]              key_src;
  logic [7:0]              key_ff;
  logic [31:0]             cnt;
  logic [31:0]             len;
  logic [31:0]             spos;
  logic [31:0]             epos;
  logic [31:0]             rd;
  logic [31:0]             c0;
  espg_pkg::espg_apb_req_t apb;
  espg_pkg::espg_apb_rsp_t rsp;
  espg_pkg::espg_pos_t     pos;
  int                      err_count;
  int                      n_checks;
  int                      lead;
  int                      wid;

  // ----------------------------------------------------------------
  // clock, key stage, design and coil
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) key_ff <= key_src;

  espg_spark #(.UNLOCK_KEY(KEY)) dut_u (
    .i_clk                    (i_clk),
    .i_rst                    (i_rst),
    .i_apb                    (apb),
    .i_engine_position_bundle (pos),
    .i_key                    (key_ff),
    .o_apb                    (rsp),
    .o_ignition_pulse_output  (line)
  );

  // spare line aux_line held low, ored onto the same channel
  assign ttl_channel_input = line | aux_line;

  espg_coil_model coil_u (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_line      (ttl_channel_input),
    .i_invert    (pol),
    .i_pos       (pos.crank_angle_tick),
    .o_count     (cnt),
    .o_len       (len),
    .o_start_pos (spos),
    .o_end_pos   (epos)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb_rw(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rdat, output logic err);
    int n;
    n = 0;
    // let one edge pass after a release before the next setup
    if (apb.psel === 1'b1) begin
      @(posedge i_clk);
    end
    apb.psel    <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite  <= w;
    apb.paddr   <= a;
    apb.pwdata  <= wd;
    @(posedge i_clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      final_report();
    end
    rdat = rsp.prdata;
    err  = rsp.pslverr;
    apb.psel    <= 1'b0;
    apb.penable <= 1'b0;
  endtask

  task automatic cfg(input logic [2:0] c, input int a, input int b, input int k,
                     input int d, input int mn, input int mx);
    apb_rw(1'b1, espg_pkg::START_OFS, 32'(a), rd, er);
    apb_rw(1'b1, espg_pkg::END_OFS, 32'(b), rd, er);
    apb_rw(1'b1, espg_pkg::CUTOFF_OFS, 32'(k), rd, er);
    apb_rw(1'b1, espg_pkg::DWELL_OFS, 32'(d), rd, er);
    apb_rw(1'b1, espg_pkg::MIN_OFS, 32'(mn), rd, er);
    apb_rw(1'b1, espg_pkg::MAX_OFS, 32'(mx), rd, er);
    apb_rw(1'b1, espg_pkg::CTRL_OFS, 32'(c), rd, er);
    pol <= c[2];
    repeat (2) @(posedge i_clk);
  endtask

  task automatic run_cycle(input int step);
    for (int p = 0; p < MAXA; p++) begin
      pos.crank_angle_tick <= 16'(p);
      repeat (step) @(posedge i_clk);
    end
    repeat (3) @(posedge i_clk);
  endtask

  // ----------------------------------------------------------------
  // timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge i_clk);
    err_count++;
    final_report();
  end

  initial begin
    void'($urandom(98));
    i_rst = 1'b1;
    pol = 1'b0;
    apb = '0;
    key_src = KEY;
    aux_line = 1'b0;
    pos.crank_angle_tick = '0;
    pos.max_angle_tick = 16'(MAXA);
    err_count = 0;
    n_checks = 0;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    check(32'(line), 32'h0);
    apb_rw(1'b0, espg_pkg::CTRL_OFS, 32'h0, rd, er);
    check(rd, 32'h0);
    apb_rw(1'b0, espg_pkg::STATUS_OFS, 32'h0, rd, er);
    check(rd, 32'h8);
    apb_rw(1'b0, 8'h40, 32'h0, rd, er);
    check(32'(er), 32'h1);
    apb_rw(1'b1, espg_pkg::MIN_OFS, 32'hab000005, rd, er);
    apb_rw(1'b0, espg_pkg::MIN_OFS, 32'h0, rd, er);
    check(rd, 32'h5);
    $display("test reset done");
    cfg(3'b010, 10, 20, 28, 3, 1, 24'hffffff);
    c0 = cnt;
    run_cycle(8);
    check(cnt, c0);
    $display("test disabled done");
    for (int i = 0; i < 4; i++) begin
      lead = 4 + int'($urandom % 16);
      wid = 2 + int'($urandom % 14);
      cfg({i[0], 2'b11}, lead, lead + wid, lead + wid + 8, 3, 1, 24'hffffff);
      check(32'(line), 32'(i[0]));
      c0 = cnt;
      run_cycle(8);
      check(cnt, c0 + 32'h1);
      check(spos, 32'(lead));
      check(epos, 32'(lead + wid));
      check(len, 32'(wid * 8));
    end
    $display("test start end done");
    cfg(3'b011, 10, 12, 40, 3, 20, 24'hffffff);
    run_cycle(8);
    check(32'(len >= 95 && len <= 106), 32'h1);
    cfg(3'b011, 10, 40, 48, 3, 1, 10);
    run_cycle(8);
    check(32'(len >= 45 && len <= 56), 32'h1);
    $display("test dwell limits done");
    cfg(3'b011, 10, 40, 20, 3, 1, 24'hffffff);
    c0 = cnt;
    run_cycle(8);
    check(epos, 32'h14);
    check(cnt, c0 + 32'h1);
    $display("test cutoff done");
    key_src <= 8'h00;
    cfg(3'b011, 10, 20, 28, 3, 1, 24'hffffff);
    c0 = cnt;
    run_cycle(8);
    check(cnt, c0);
    key_src <= KEY;
    $display("test key done");
    cfg(3'b001, 5, 40, 50, 20, 1, 24'hffffff);
    run_cycle(10);
    c0 = cnt;
    run_cycle(10);
    check(cnt, c0 + 32'h1);
    check(spos, 32'h1e);
    check(len, 32'h64);
    check(epos, 32'h28);
    apb_rw(1'b0, espg_pkg::PERIOD_OFS, 32'h0, rd, er);
    check(rd, 32'h2);
    apb_rw(1'b0, espg_pkg::LAST_OFS, 32'h0, rd, er);
    check(32'(rd >= 32'h13 && rd <= 32'h14), 32'h1);
    $display("test dwell mode done");
    final_report();
  end
endmodule
